// ### rtl/rcs_clock_switch.sv
// Purpose: redundant reference clock switch and digital clock multiplier
// Assumes: references and control pins are asynchronous to mclk
// Notes:   outputs are mclk-sampled approximations of the multiplied clocks
`timescale 1ns/1ps
module rcs_clock_switch (
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire logic                        ce,
    input  wire logic                        ref_in_first,
    input  wire logic                        ref_in_second,
    input  wire logic                        ref_select,
    input  wire logic                        switch_mode_select,
    input  wire logic                        alarm_reset_n,
    input  wire logic                        bypass_select,
    input  wire logic [rcs_pkg::RATIO_W-1:0] ratio_select,
    input  wire logic                        output_disable_reset,
    output logic      [rcs_pkg::BANK_N-1:0]  bank_one_outputs,
    output logic      [rcs_pkg::BANK_N-1:0]  bank_two_outputs,
    output logic                             bank_oe,
    output logic                             feedback_out,
    output logic                             fail_flag_first_n,
    output logic                             fail_flag_second_n,
    output logic                             active_ref_indicator
);
    localparam int SW = 7 + rcs_pkg::RATIO_W; // seven single pins plus ratio

    logic [SW-1:0] pins;
    logic [SW-1:0] pins_s;
    logic          ref1_s;
    logic          ref2_s;
    logic          sel_s;
    logic          mode_s;
    logic          alarm_s;
    logic          byp_s;
    logic          dis_s;
    logic [3:0]    ratio_s;
    logic          rst_int;
    logic          rise1;
    logic          rise2;
    logic          fail1;
    logic          fail2;
    logic          alarm_prev;
    logic          alarm_shot;
    logic          auto_en;
    logic          active_fail;
    logic          other_fail;
    logic          next_active;
    logic          sel_lvl;
    logic          sel_rise;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation; disable and alarm reset travel inverted so that a
    // flushed synchroniser reads them as disable asserted and alarm reset idle
    assign pins = {ratio_select, ~output_disable_reset, bypass_select, ~alarm_reset_n,
                   switch_mode_select, ref_select, ref_in_second, ref_in_first};

    rcs_sync #(
        .W (SW)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .d       (pins),
        .q       (pins_s)
    );

    // unpack synchronised pins
    // the two inverted pins are turned back to their pin polarity here
    assign ref1_s  = pins_s[0];
    assign ref2_s  = pins_s[1];
    assign sel_s   = pins_s[2];
    assign mode_s  = pins_s[3];
    assign alarm_s = ~pins_s[4];
    assign byp_s   = pins_s[5];
    assign dis_s   = ~pins_s[6];
    assign ratio_s = pins_s[SW-1:7];
    assign rst_int = sys_rst | dis_s;

    ////////////////////////////////////////////////////////////////////////
    // reference monitors, each counting edges of the other
    rcs_ref_monitor u_mon_first (
        .mclk      (mclk),
        .rst       (rst_int),
        .ce        (ce),
        .own_ref   (ref1_s),
        .other_ref (ref2_s),
        .own_rise  (rise1),
        .fail      (fail1)
    );

    rcs_ref_monitor u_mon_second (
        .mclk      (mclk),
        .rst       (rst_int),
        .ce        (ce),
        .own_ref   (ref2_s),
        .other_ref (ref1_s),
        .own_rise  (rise2),
        .fail      (fail2)
    );

    ////////////////////////////////////////////////////////////////////////
    // reference selection
    assign alarm_shot  = alarm_prev & ~alarm_s;
    assign auto_en     = mode_s & ~byp_s;
    assign active_fail = active_ref_indicator ? fail2 : fail1;
    assign other_fail  = active_ref_indicator ? fail1 : fail2;
    assign next_active = (alarm_shot || !auto_en) ? sel_s :
                         (active_fail && !other_fail) ? ~active_ref_indicator :
                         active_ref_indicator;
    assign sel_lvl     = active_ref_indicator ? ref2_s : ref1_s;
    assign sel_rise    = active_ref_indicator ? rise2 : rise1;

    // active reference, alarm edge and sticky active-low flags; failure beats clear
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            active_ref_indicator <= rcs_pkg::ACTIVE_RST;
            alarm_prev           <= 1'b1;
            fail_flag_first_n    <= 1'b1;
            fail_flag_second_n   <= 1'b1;
        end else if (ce) begin
            active_ref_indicator <= next_active;
            alarm_prev           <= alarm_s;
            if (fail1) begin
                fail_flag_first_n <= 1'b0;
            end else if (alarm_shot) begin
                fail_flag_first_n <= 1'b1;
            end
            if (fail2) begin
                fail_flag_second_n <= 1'b0;
            end else if (alarm_shot) begin
                fail_flag_second_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period measurement and phase tracking of the selected reference
    logic [15:0] per_cnt;
    logic [15:0] period;
    logic [15:0] phase;
    logic [15:0] next_phase;
    logic [15:0] ph_inc;
    logic [15:0] gap;
    logic        early;
    logic        wrap;

    assign ph_inc = phase + 16'h0001;
    assign gap    = period - phase;
    assign early  = phase < {1'b0, period[15:1]};
    // at a reference edge the phase moves at most one step toward zero
    assign next_phase = !sel_rise ? ((ph_inc >= period) ? 16'h0000 : ph_inc) :
                        early ? ((phase <= rcs_pkg::SLEW_STEP) ? 16'h0000 :
                                 phase - rcs_pkg::SLEW_STEP) :
                        (gap <= rcs_pkg::SLEW_STEP) ? 16'h0000 : phase + rcs_pkg::SLEW_STEP;
    assign wrap   = (next_phase == 16'h0000) && (phase != 16'h0000);

    // period counter and phase counter
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            per_cnt <= 16'h0000;
            period  <= rcs_pkg::PERIOD_RST;
            phase   <= 16'h0000;
        end else if (ce) begin
            phase <= next_phase;
            if (sel_rise) begin
                per_cnt <= 16'h0000;
                if (ph_inc_ok(per_cnt)) begin
                    period <= per_cnt + 16'h0001;
                end
            end else if (per_cnt != 16'hFFFF) begin
                per_cnt <= per_cnt + 16'h0001;
            end
        end
    end

    // accept only plausible periods
    function automatic logic ph_inc_ok(input logic [15:0] cnt);
        ph_inc_ok = (cnt >= rcs_pkg::PERIOD_MIN) && (cnt != 16'hFFFF);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // multiplied clock: accumulator toggles 2*mult times per reference period
    logic [3:0]  mult;
    logic [16:0] acc_sum;
    logic [15:0] acc;
    logic        fast;
    logic        half;
    logic        half_mode;

    assign mult      = rcs_pkg::rcs_mult(ratio_s[2:0]);
    assign acc_sum   = {1'b0, acc} + {12'h000, mult, 1'b0};
    assign half_mode = ratio_s[rcs_pkg::HALF_BIT];

    // fast restarts high on each phase wrap; half only follows fast edges
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            acc  <= 16'h0000;
            fast <= 1'b1;
            half <= 1'b1;
        end else if (ce) begin
            if (wrap) begin
                acc  <= 16'h0000;
                fast <= 1'b1;
                if (!fast) begin
                    half <= ~half;
                end
            end else if (acc_sum >= {1'b0, period}) begin
                acc  <= acc_sum[15:0] - period;
                fast <= ~fast;
                if (!fast) begin
                    half <= ~half;
                end
            end else begin
                acc <= acc_sum[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage: bypass passes the reference, disable tristates the banks
    logic bank_a;
    logic bank_b;

    assign bank_a = byp_s ? sel_lvl : fast;
    assign bank_b = byp_s ? sel_lvl : (half_mode ? half : fast);

    // registered outputs; the feedback copy has no enable of its own
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            bank_one_outputs <= '0;
            bank_two_outputs <= '0;
            bank_oe          <= 1'b0;
            feedback_out     <= 1'b0;
        end else if (ce) begin
            bank_one_outputs <= {rcs_pkg::BANK_N{bank_a}};
            bank_two_outputs <= {rcs_pkg::BANK_N{bank_b}};
            bank_oe          <= 1'b1;
            feedback_out     <= bank_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_disable_tristate: assert property (@(posedge mclk) disable iff (sys_rst)
        dis_s |=> !bank_oe && fail_flag_first_n && fail_flag_second_n)
        else $error("banks driven while disabled");
    a_flag_first_set: assert property (@(posedge mclk) disable iff (rst_int)
        ce && fail1 |=> !fail_flag_first_n) else $error("first alarm not raised");
    a_flag_second_set: assert property (@(posedge mclk) disable iff (rst_int)
        ce && fail2 |=> !fail_flag_second_n) else $error("second alarm not raised");
    // flags stay low until the alarm one-shot or a reset
    a_flag_first_hold: assert property (@(posedge mclk) disable iff (rst_int)
        ce && !fail_flag_first_n && !alarm_shot |=> !fail_flag_first_n)
        else $error("first alarm dropped without reset");
    a_flag_second_hold: assert property (@(posedge mclk) disable iff (rst_int)
        ce && !fail_flag_second_n && !alarm_shot |=> !fail_flag_second_n)
        else $error("second alarm dropped without reset");
    a_oe_release: assert property (@(posedge mclk) disable iff (rst_int)
        ce |=> bank_oe)
        else $error("banks not driven after disable released");
    a_alarm_oneshot: assert property (@(posedge mclk) disable iff (rst_int)
        ce && alarm_shot && !fail1 && !fail2 |=> fail_flag_first_n && fail_flag_second_n
        && active_ref_indicator == $past(sel_s)) else $error("alarm reset had no effect");
    a_manual_follow: assert property (@(posedge mclk) disable iff (rst_int)
        ce && !auto_en |=> active_ref_indicator == $past(sel_s)) else $error("manual select ignored");
    a_auto_switch: assert property (@(posedge mclk) disable iff (rst_int)
        ce && auto_en && !alarm_shot && active_fail && !other_fail
        |=> active_ref_indicator != $past(active_ref_indicator)) else $error("no failover");
    a_auto_hold: assert property (@(posedge mclk) disable iff (rst_int)
        ce && auto_en && !alarm_shot && !active_fail |=> $stable(active_ref_indicator))
        else $error("reference changed without failure");
    a_bypass_pass: assert property (@(posedge mclk) disable iff (rst_int)
        ce && byp_s |=> bank_one_outputs[0] == $past(sel_lvl) && bank_two_outputs[0] == $past(sel_lvl))
        else $error("bypass not passing reference");
    a_bank_same: assert property (@(posedge mclk) disable iff (rst_int)
        ce && !half_mode |=> bank_two_outputs == bank_one_outputs) else $error("banks differ at full rate");
    a_wrap_edge: assert property (@(posedge mclk) disable iff (rst_int)
        ce && wrap && !byp_s |=> ##1 bank_one_outputs[0] && feedback_out) else $error("wrap not aligned");

    c_failover: cover property (@(posedge mclk) disable iff (rst_int)
        auto_en && active_fail && !other_fail ##1 $changed(active_ref_indicator));
    c_alarm_reset: cover property (@(posedge mclk) disable iff (rst_int) alarm_shot);
    c_bypass: cover property (@(posedge mclk) disable iff (rst_int) byp_s && sel_rise);
    c_half_rate: cover property (@(posedge mclk) disable iff (rst_int) half_mode && $rose(bank_two_outputs[0]));
endmodule

// ### rtl/rcs_pkg.sv
// Purpose: shared constants for the redundant reference clock switch
// Assumes: references are slow against mclk (many mclk cycles per period)
// Notes:   ratio code table and limits are fixed here
package rcs_pkg;
    localparam int          PER_W      = 16;       // period and phase counter width
    localparam int          BANK_N     = 6;        // outputs per bank
    localparam int          RATIO_W    = 4;        // ratio select width
    localparam int          HALF_BIT   = 3;        // ratio bit: bank two at half rate
    localparam logic [2:0]  MISS_LIMIT = 3'h4;     // other-ref edges without own edge
    localparam logic [15:0] SLEW_STEP  = 16'h0004; // largest phase fix per ref edge
    localparam logic [15:0] PERIOD_RST = 16'h0100; // period guess before first measure
    localparam logic [15:0] PERIOD_MIN = 16'h0010; // shorter periods are ignored
    localparam logic        ACTIVE_RST = 1'b0;     // first reference after reset
    localparam logic [2:0]  CODE_X1    = 3'h0;
    localparam logic [2:0]  CODE_X2    = 3'h1;
    localparam logic [2:0]  CODE_X3    = 3'h2;
    localparam logic [2:0]  CODE_X4    = 3'h3;
    localparam logic [2:0]  CODE_X8    = 3'h4;

    // multiplication factor for a ratio code; unused codes fall back to one
    function automatic logic [3:0] rcs_mult(input logic [2:0] code);
        case (code)
            CODE_X2: rcs_mult = 4'h2;
            CODE_X3: rcs_mult = 4'h3;
            CODE_X4: rcs_mult = 4'h4;
            CODE_X8: rcs_mult = 4'h8;
            default: rcs_mult = 4'h1;
        endcase
    endfunction
endpackage

// ### rtl/rcs_ref_monitor.sv
// Purpose: missing-edge watchdog for one reference
// Assumes: both inputs already synchronised
// Notes:   failure is a live level; it drops at the next own edge
`timescale 1ns/1ps
module rcs_ref_monitor (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic own_ref,
    input  wire logic other_ref,
    output logic      own_rise,
    output logic      fail
);
    logic       own_prev;
    logic       other_prev;
    logic [2:0] miss_cnt;
    logic       other_rise;

    // edge detection on synchronised levels
    assign own_rise   = own_ref & ~own_prev;
    assign other_rise = other_ref & ~other_prev;
    assign fail       = (miss_cnt == rcs_pkg::MISS_LIMIT);

    // count other-reference edges since our last edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            own_prev   <= own_ref;   // no false edge at release
            other_prev <= other_ref;
            miss_cnt   <= 3'h0;
        end else if (ce) begin
            own_prev   <= own_ref;
            other_prev <= other_ref;
            if (own_rise) begin
                miss_cnt <= 3'h0;
            end else if (other_rise && !fail) begin
                miss_cnt <= miss_cnt + 3'h1;
            end
        end
    end

    a_miss_clear: assert property (@(posedge mclk) disable iff (rst)
        ce && own_rise |=> !fail) else $error("monitor stays failed after own edge");
    a_miss_count: assert property (@(posedge mclk) disable iff (rst)
        ce && other_rise && !own_rise && miss_cnt == 3'h3 |=> fail)
        else $error("monitor missed the failure limit");
    c_fail_seen: cover property (@(posedge mclk) disable iff (rst) $rose(fail));
endmodule

// ### rtl/rcs_sync.sv
// Purpose: two-stage synchroniser for a bus of pin inputs
// Assumes: bits are independent levels
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module rcs_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // two flops in series
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### verif/rcs_clock_switch_bench.sv
// Purpose: self-checking bench for the redundant reference clock switch
// Assumes: reference periods of about 160 mclk cycles
// Notes:   inputs change 5 ns after the rising edge of mclk
`timescale 1ns/1ps
module rcs_clock_switch_bench;
    logic                        mclk;
    logic                        sys_rst;
    logic                        ce;
    logic                        run_first;
    logic                        run_second;
    logic                        ref_in_first;
    logic                        ref_in_second;
    logic                        ref_select;
    logic                        switch_mode_select;
    logic                        alarm_reset_n;
    logic                        bypass_select;
    logic [rcs_pkg::RATIO_W-1:0] ratio_select;
    logic                        output_disable_reset;
    logic [rcs_pkg::BANK_N-1:0]  bank_one_outputs;
    logic [rcs_pkg::BANK_N-1:0]  bank_two_outputs;
    logic                        bank_oe;
    logic                        feedback_out;
    logic                        fail_flag_first_n;
    logic                        fail_flag_second_n;
    logic                        active_ref_indicator;
    int                          err_count;
    int                          comparisons;

    ////////////////////////////////////////////////////////////////////////////////
    // design and reference sources
    rcs_clock_switch u_rcs_clock_switch (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .ref_in_first(ref_in_first), .ref_in_second(ref_in_second), .ref_select(ref_select),
        .switch_mode_select(switch_mode_select), .alarm_reset_n(alarm_reset_n),
        .bypass_select(bypass_select), .ratio_select(ratio_select),
        .output_disable_reset(output_disable_reset), .bank_one_outputs(bank_one_outputs),
        .bank_two_outputs(bank_two_outputs), .bank_oe(bank_oe), .feedback_out(feedback_out),
        .fail_flag_first_n(fail_flag_first_n), .fail_flag_second_n(fail_flag_second_n),
        .active_ref_indicator(active_ref_indicator));
    rcs_ref_pair u_rcs_ref_pair (.run_first(run_first), .run_second(run_second),
        .ref_in_first(ref_in_first), .ref_in_second(ref_in_second));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int seen);
        comparisons++;
        if (seen < lo || seen > hi) begin
            err_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask

    // counts rising edges of both banks over n cycles
    task automatic count_edges(input int n, output int c1, output int c2);
        logic p1;
        logic p2;
        c1 = 0;
        c2 = 0;
        p1 = bank_one_outputs[0];
        p2 = bank_two_outputs[0];
        repeat (n) begin
            tick(1);
            if (bank_one_outputs[0] === 1'b1 && p1 === 1'b0) c1++;
            if (bank_two_outputs[0] === 1'b1 && p2 === 1'b0) c2++;
            p1 = bank_one_outputs[0];
            p2 = bank_two_outputs[0];
        end
    endtask

    // waits a bounded time for a flag to reach a level
    task automatic wait_level(ref logic sig, input logic lvl, input int limit);
        int k;
        for (k = 0; k < limit && sig !== lvl; k++) tick(1);
    endtask

    task automatic conclude;
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_power_up;
        output_disable_reset = 1'b1;
        tick(6);
        sys_rst = 1'b0;
        tick(400);
        check_bit("oe_in_reset", 1'b0, bank_oe);
        check_bit("flag_first_reset", 1'b1, fail_flag_first_n);
        check_bit("indicator_reset", 1'b0, active_ref_indicator);
        output_disable_reset = 1'b0;
        tick(6);
        check_bit("oe_after_release", 1'b1, bank_oe);
    endtask

    task automatic test_ratios;
        int m[6] = '{1, 2, 3, 4, 8, 1};
        int i;
        int c1;
        int c2;
        for (i = 0; i < 6; i++) begin
            ratio_select = {m[i][0] ? 1'b1 : 1'b0, 3'(i)};
            tick(800);
            count_edges(640, c1, c2);
            check_range("bank_one_edges", 4 * m[i] - 2, 4 * m[i] + 2, c1);
            check_range("bank_two_edges", (m[i][0] ? 2 : 4) * m[i] - 2, (m[i][0] ? 2 : 4) * m[i] + 2, c2);
            check_bit("feedback_follows", bank_one_outputs[0], feedback_out);
        end
        ratio_select = 4'h0;
    endtask

    task automatic test_manual;
        switch_mode_select = 1'b0;
        ref_select = 1'b1;
        tick(4);
        check_bit("manual_indicator", 1'b1, active_ref_indicator);
        run_second = 1'b0;
        wait_level(fail_flag_second_n, 1'b0, 1200);
        tick(50);
        check_bit("manual_flag_second", 1'b0, fail_flag_second_n);
        check_bit("manual_no_failover", 1'b1, active_ref_indicator);
        run_second = 1'b1;
        ref_select = 1'b0;
        tick(400);
        check_bit("manual_back_first", 1'b0, active_ref_indicator);
        alarm_reset_n = 1'b0;
        tick(4);
        alarm_reset_n = 1'b1;
        tick(4);
        check_bit("manual_flag_cleared", 1'b1, fail_flag_second_n);
    endtask

    task automatic test_failover;
        switch_mode_select = 1'b1;
        run_first = 1'b0;
        wait_level(fail_flag_first_n, 1'b0, 1200);
        check_bit("auto_flag_first", 1'b0, fail_flag_first_n);
        tick(1);
        check_bit("auto_to_second", 1'b1, active_ref_indicator);
        check_bit("second_still_ok", 1'b1, fail_flag_second_n);
        run_first = 1'b1;
        tick(400);
        run_second = 1'b0;
        wait_level(active_ref_indicator, 1'b0, 1200);
        check_bit("auto_back_first", 1'b0, active_ref_indicator);
        run_second = 1'b1;
        ref_select = 1'b1;
        tick(400);
        check_bit("auto_ignores_select", 1'b0, active_ref_indicator);
        alarm_reset_n = 1'b0;
        tick(4);
        check_bit("alarm_flag_first", 1'b1, fail_flag_first_n);
        check_bit("alarm_flag_second", 1'b1, fail_flag_second_n);
        check_bit("alarm_to_select", 1'b1, active_ref_indicator);
        alarm_reset_n = 1'b1;
        ref_select = 1'b0;
    endtask

    task automatic test_bypass;
        int c1;
        int c2;
        bypass_select = 1'b1;
        switch_mode_select = 1'b1;
        alarm_reset_n = 1'b0;
        tick(4);
        alarm_reset_n = 1'b1;
        tick(200);
        count_edges(640, c1, c2);
        check_range("bypass_edges", 3, 5, c1);
        run_first = 1'b0;
        tick(1000);
        check_bit("bypass_no_failover", 1'b0, active_ref_indicator);
        count_edges(400, c1, c2);
        check_range("bypass_static", 0, 0, c1);
        run_first = 1'b1;
        bypass_select = 1'b0;
        tick(400);
    endtask

    // clock enable low freezes the banks although the reference runs on
    task automatic test_freeze;
        logic held;
        ce = 1'b0;
        held = bank_one_outputs[0];
        tick(200);
        check_bit("freeze_bank_one", held, bank_one_outputs[0]);
        check_bit("freeze_oe", 1'b1, bank_oe);
        ce = 1'b1;
        tick(400);
    endtask

    task automatic test_disable;
        output_disable_reset = 1'b1;
        tick(4);
        check_bit("oe_disabled", 1'b0, bank_oe);
        tick(400);
        check_bit("disable_clears_flag", 1'b1, fail_flag_first_n);
        output_disable_reset = 1'b0;
        tick(6);
        check_bit("oe_restored", 1'b1, bank_oe);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        err_count = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        run_first = 1'b1;
        run_second = 1'b1;
        ref_select = 1'b0;
        switch_mode_select = 1'b0;
        alarm_reset_n = 1'b1;
        bypass_select = 1'b0;
        ratio_select = 4'h0;
        output_disable_reset = 1'b1;
        test_power_up();
        test_ratios();
        test_manual();
        test_failover();
        test_bypass();
        test_freeze();
        test_disable();
        conclude();
    end

    initial begin
        #2000000;
        err_count++;
        conclude();
    end
endmodule

// ### verif/rcs_ref_pair.sv
// Purpose: two free-running reference clock sources for the clock switch
// Assumes: each source can be stopped and restarted by the bench
// Notes:   a stopped source holds its last level; periods differ so phases drift
`timescale 1ns/1ps
module rcs_ref_pair #(
    parameter int HALF_FIRST  = 4000,
    parameter int HALF_SECOND = 4050
) (
    input  wire logic run_first,
    input  wire logic run_second,
    output logic      ref_in_first,
    output logic      ref_in_second
);
    ////////////////////////////////////////////////////////////////////////////////
    // first source: toggles only while running
    initial begin
        ref_in_first = 1'b0;
        forever begin
            #(HALF_FIRST);
            if (run_first) ref_in_first = ~ref_in_first;
        end
    end

    // second source: offset start keeps it unrelated to the first
    initial begin
        ref_in_second = 1'b0;
        #1237;
        forever begin
            #(HALF_SECOND);
            if (run_second) ref_in_second = ~ref_in_second;
        end
    end
endmodule
